// *** hdl/motor_io_map.svh ***
// register offsets, field positions, reset values, function codes, timing
// assumes a 125 MHz core clock; included by the package, whose macros the modules then use
`ifndef MOTOR_IO_MAP_SVH
`define MOTOR_IO_MAP_SVH

`define NUM_IN 7
`define NUM_OUT 2
`define IN_CODE_W 6
`define OUT_CODE_W 7
`define AXIS_W 4
`define IRQ_W 3

// register byte offsets
`define OFF_IN_LO 8'h00
`define OFF_IN_HI 8'h04
`define OFF_OUT 8'h08
`define OFF_SW 8'h0C
`define OFF_STATUS 8'h10
`define OFF_IRQ_STAT 8'h14
`define OFF_IRQ_CLR 8'h18
`define OFF_IRQ_EN 8'h1C

// switch register fields
`define SW_AXIS_EXTRA 0
`define SW_PROTOCOL 1
`define SW_AXIS_LSB 4
`define SW_RST 8'h00

// status register fields
`define ST_FAULT 8
`define ST_RUN_LSB 9

// interrupt bits
`define IRQ_FAULT 0
`define IRQ_THERMAL 1
`define IRQ_STOP 2

// input function codes
`define FN_FORWARD 6'h01
`define FN_REVERSE 6'h02
`define FN_STOP_STYLE 6'h13
`define FN_BRAKE 6'h14
`define FN_EXT_FAULT 6'h15
`define FN_THERMAL 6'h16
`define FN_FAULT_CLR 6'h18
`define FN_PANEL 6'h1B
`define FN_REMOTE0 6'h20
`define FN_SPEED_SEL0 6'h30
`define FN_TORQUE 6'h36
`define FN_LAST 54

// output source codes
`define SRC_FAULT1 7'h41
`define SRC_WARN 7'h42
`define SRC_MOVING 7'h44
`define SRC_TLC 7'h47
`define SRC_VA 7'h4D
`define SRC_BUSY 7'h50
`define SRC_FAULT2 7'h51
`define SRC_MPS 7'h52
`define SRC_DIR 7'h54
`define SRC_PULSE 7'h55

// reset assignments, terminal 0 in the low field
`define IN_CODE_RST {6'h16, 6'h14, 6'h18, 6'h30, 6'h13, 6'h02, 6'h01}
`define OUT_CODE_RST {7'h41, 7'h55}

// timing
`define CLK_PERIOD_NS 8
`define PULSE_WIDTH_NS 200000
`define DEBOUNCE_NS 100000
`define BLINK_HALF_NS 250000000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** hdl/motor_io_pkg.sv ***
// types shared by the terminal logic of the motor driver
// assumes motor_io_map.svh is on the include path
`include "motor_io_map.svh"
package motor_io_pkg;
  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_FWD = 2'b01,
    RUN_REV = 2'b10,
    RUN_DECEL = 2'b11
  } run_state_t;

  typedef logic [`NUM_IN-1:0][`IN_CODE_W-1:0] in_codes_t;
  typedef logic [`NUM_OUT-1:0][`OUT_CODE_W-1:0] out_codes_t;

  typedef struct packed {
    run_state_t run;
    in_codes_t in_code;
    out_codes_t out_code;
    logic [`AXIS_W-1:0] axis_sel;
    logic fsw_axis;
    logic fsw_proto;
    logic fault;
    logic therm_open;
    logic [27:0] blink_cnt;
    logic blink;
    logic [`IRQ_W-1:0] irq_stat;
    logic [`IRQ_W-1:0] irq_en;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic run_fwd;
    logic run_rev;
    logic decel;
    logic brake_release;
    logic fault_led;
    logic [`NUM_OUT-1:0] out_term;
    logic irq;
    logic torque_limit;
    logic panel_release;
    logic [15:0] remote;
    logic [3:0] speed_sel;
    logic [`AXIS_W:0] axis_number;
    logic modbus_mode;
  } ctrl_state_t;
endpackage

// *** hdl/term_if.sv ***
// carries raw and filtered terminal levels between the top and its filter
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface term_if #(parameter int N = 7) ();
  logic [N-1:0] raw;
  logic [N-1:0] clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface
`default_nettype wire

// *** hdl/term_filter.sv ***
// two-flop synchroniser and stability filter for each input terminal
// assumes clk_i and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module term_filter #(
  parameter int N = 7,
  parameter int CYCLES = 12500
) (
  input wire logic clk_i,
  input wire logic reset_i,
  term_if.filt term
);
  typedef struct packed {
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] clean;
    logic [N-1:0][15:0] cnt;
  } filt_state_t;
  filt_state_t s, next_s;

  if (CYCLES < 1 || CYCLES > 65535) begin : bad_cycles
    $error("term_filter: CYCLES out of range");
  end

  always_comb begin
    next_s = s;
    next_s.sync1 = term.raw;
    next_s.sync2 = s.sync1;
    for (int i = 0; i < N; i++) begin
      if (s.sync2[i] == s.clean[i]) begin
        next_s.cnt[i] = '0;
      end else if (s.cnt[i] == 16'(CYCLES - 1)) begin
        next_s.clean[i] = s.sync2[i];
        next_s.cnt[i] = '0;
      end else begin
        next_s.cnt[i] = s.cnt[i] + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign term.clean = s.clean;

  filter_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $changed(s.clean) |-> $past(s.sync2) == s.clean)
    else $error("filtered level changed without a stable sample");
endmodule // term_filter
`default_nettype wire

// *** hdl/rotation_pulse.sv ***
// stretches each motion tick into one fixed-width rotation pulse
// assumes one tick per thirtieth of an output shaft revolution
`timescale 1ns/1ps
`default_nettype none
module rotation_pulse #(
  parameter int WIDTH = 25000
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic tick_i,
  output logic pulse_o
);
  typedef struct packed {
    logic [15:0] cnt;
    logic pulse;
  } pulse_state_t;
  pulse_state_t s, next_s;
  logic [15:0] high_cnt;

  if (WIDTH < 1 || WIDTH > 65535) begin : bad_width
    $error("rotation_pulse: WIDTH out of range");
  end

  always_comb begin
    next_s = s;
    if (tick_i) begin
      next_s.cnt = 16'(WIDTH - 1);
      next_s.pulse = 1'b1;
    end else if (s.cnt != '0) begin
      next_s.cnt = s.cnt - 16'h0001;
    end else begin
      next_s.pulse = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pulse_o = s.pulse;

  always_ff @(posedge clk_i) begin
    if (reset_i || tick_i || !s.pulse) begin
      high_cnt <= '0;
    end else begin
      high_cnt <= high_cnt + 16'h0001;
    end
  end

  pulse_width_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(pulse_o) |-> $past(high_cnt) == 16'(WIDTH - 1))
    else $error("rotation pulse width is wrong");
endmodule // rotation_pulse
`default_nettype wire

// *** hdl/motor_io_top.sv ***
// terminal assignment, run control, fault handling and register slave
// assumes AXI4-Lite master on clk_i and a motor core giving status lines
`timescale 1ns/1ps
`default_nettype none
// Operation
// - switch two bit one extends axis number
// - switch two bit two picks Modbus protocol
// - each input terminal decodes a coded function
// - each output terminal drives a coded source
// - input codes reset to documented default order
// - forward and reverse inputs run the motor
// - stop style picks instant or ramped stop
// - thermal input normally closed, open stops motor
// - brake release input frees brake, clear clears faults
// - outputs reset to rotation pulse and fault
// - thirty pulses per revolution, each 0.2 ms
// - fault output conducts when healthy, opens on fault
// - trip turns fault off, blinks lamp, stops
// - trip engages brake on brake variants
module motor_io_top
  import motor_io_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES =
    (`DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int PULSE_CYCLES =
    (`PULSE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int BLINK_CYCLES = `BLINK_HALF_NS / `CLK_PERIOD_NS,
  parameter bit BRAKE_FITTED = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [`NUM_IN-1:0] in_term_i,
  input wire logic shaft_tick_i,
  input wire logic protect_trip_i,
  input wire logic motor_still_i,
  input wire logic warning_flag_i,
  input wire logic torque_limited_flag_i,
  input wire logic speed_reached_flag_i,
  input wire logic busy_flag_i,
  input wire logic main_power_flag_i,
  input wire logic axi_awvalid_i,
  output logic axi_awready_o,
  input wire logic [7:0] axi_awaddr_i,
  input wire logic axi_wvalid_i,
  output logic axi_wready_o,
  input wire logic [31:0] axi_wdata_i,
  input wire logic [3:0] axi_wstrb_i,
  output logic axi_bvalid_o,
  input wire logic axi_bready_i,
  output logic [1:0] axi_bresp_o,
  input wire logic axi_arvalid_i,
  output logic axi_arready_o,
  input wire logic [7:0] axi_araddr_i,
  output logic axi_rvalid_o,
  input wire logic axi_rready_i,
  output logic [31:0] axi_rdata_o,
  output logic [1:0] axi_rresp_o,
  output logic run_fwd_o,
  output logic run_rev_o,
  output logic decel_o,
  output logic brake_release_o,
  output logic fault_led_o,
  output logic [`NUM_OUT-1:0] out_term_o,
  output logic torque_limit_enable_o,
  output logic panel_release_o,
  output logic [15:0] remote_bits_o,
  output logic [3:0] speed_data_select_o,
  output logic [`AXIS_W:0] axis_number_o,
  output logic modbus_mode_o,
  output logic irq_o
);
  import motor_io_pkg::*;

  if (BLINK_CYCLES < 1 || BLINK_CYCLES >= (1 << 28)) begin : bad_blink
    $error("motor_io_top: BLINK_CYCLES out of range");
  end

  // ----------------------------------------
  // terminal filter and rotation pulse
  // ----------------------------------------
  term_if #(.N(`NUM_IN)) tif ();
  logic [`NUM_IN-1:0] clean;
  logic pulse;

  assign tif.raw = in_term_i;
  assign clean = tif.clean;

  term_filter #(.N(`NUM_IN), .CYCLES(DEBOUNCE_CYCLES)) u_filter (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .term(tif.filt)
  );

  rotation_pulse #(.WIDTH(PULSE_CYCLES)) u_pulse (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_i(shaft_tick_i),
    .pulse_o(pulse)
  );

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic fn_active(input in_codes_t code,
                                     input logic [`NUM_IN-1:0] lvl,
                                     input logic [5:0] fn);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `NUM_IN; i++) begin
      hit = hit | (lvl[i] && code[i] == fn);
    end
    return hit;
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    return a inside {`OFF_IN_LO, `OFF_IN_HI, `OFF_OUT, `OFF_SW,
                     `OFF_STATUS, `OFF_IRQ_STAT, `OFF_IRQ_CLR, `OFF_IRQ_EN};
  endfunction

  function automatic logic [31:0] rd_word(input ctrl_state_t st,
                                          input logic [7:0] a,
                                          input logic [`NUM_IN-1:0] lvl);
    logic [31:0] d;
    d = '0;
    case (a)
      `OFF_IN_LO: begin
        for (int i = 0; i < 4; i++) d[8*i +: 6] = st.in_code[i];
      end
      `OFF_IN_HI: begin
        for (int i = 0; i < 3; i++) d[8*i +: 6] = st.in_code[i+4];
      end
      `OFF_OUT: begin
        d[6:0] = st.out_code[0];
        d[14:8] = st.out_code[1];
      end
      `OFF_SW: begin
        d[`SW_AXIS_EXTRA] = st.fsw_axis;
        d[`SW_PROTOCOL] = st.fsw_proto;
        d[`SW_AXIS_LSB +: `AXIS_W] = st.axis_sel;
      end
      `OFF_STATUS: begin
        d[`NUM_IN-1:0] = lvl;
        d[`ST_FAULT] = st.fault;
        d[`ST_RUN_LSB +: 2] = st.run;
      end
      `OFF_IRQ_STAT: d[`IRQ_W-1:0] = st.irq_stat;
      `OFF_IRQ_EN: d[`IRQ_W-1:0] = st.irq_en;
      default: d = '0;
    endcase
    return d;
  endfunction

  // ----------------------------------------
  // state update
  // ----------------------------------------
  ctrl_state_t s, next_s;
  logic forward_run, reverse_run, stop_ramp, thermal_open, fault_set, fault_clr, halt;
  logic [`IRQ_W-1:0] ev, clr;
  logic [127:0] src;
  logic [31:0] wd;

  always_comb begin
    next_s = s;
    ev = '0;
    clr = '0;
    wd = '0;
    src = '0;
    forward_run = fn_active(s.in_code, clean, `FN_FORWARD);
    reverse_run = fn_active(s.in_code, clean, `FN_REVERSE);
    stop_ramp = fn_active(s.in_code, clean, `FN_STOP_STYLE);
    thermal_open = fn_active(s.in_code, ~clean, `FN_THERMAL);
    fault_set = protect_trip_i ||
                fn_active(s.in_code, clean, `FN_EXT_FAULT);
    fault_clr = fn_active(s.in_code, clean, `FN_FAULT_CLR);

    // latched fault, a new trip wins over the clear
    next_s.fault = fault_set | (s.fault & ~fault_clr);
    next_s.therm_open = thermal_open;
    halt = next_s.fault || thermal_open;

    unique case (s.run)
      RUN_IDLE: begin
        if (!halt && forward_run && !reverse_run) next_s.run = RUN_FWD;
        else if (!halt && reverse_run && !forward_run) next_s.run = RUN_REV;
      end
      RUN_FWD, RUN_REV: begin
        if (halt) begin
          next_s.run = RUN_IDLE;
        end else if ((s.run == RUN_FWD) ? !(forward_run && !reverse_run) : !(reverse_run && !forward_run))
        begin
          next_s.run = stop_ramp ? RUN_DECEL : RUN_IDLE;
        end
      end
      RUN_DECEL: begin
        if (halt || motor_still_i) next_s.run = RUN_IDLE;
      end
    endcase

    // fault lamp blinks while a fault is latched
    if (!next_s.fault) begin
      next_s.blink_cnt = '0;
      next_s.blink = 1'b1;
    end else if (s.blink_cnt == 28'(BLINK_CYCLES - 1)) begin
      next_s.blink_cnt = '0;
      next_s.blink = ~s.blink;
    end else begin
      next_s.blink_cnt = s.blink_cnt + 28'h0000001;
    end

    // register write once address and data are both held
    if (s.aw_have && s.w_have && !s.bvalid) begin
      wd = rd_word(s, s.aw_addr, clean);
      for (int b = 0; b < 4; b++) begin
        if (s.w_strb[b]) wd[8*b +: 8] = s.w_data[8*b +: 8];
      end
      case (s.aw_addr)
        `OFF_IN_LO: begin
          for (int i = 0; i < 4; i++) next_s.in_code[i] = wd[8*i +: 6];
        end
        `OFF_IN_HI: begin
          for (int i = 0; i < 3; i++) next_s.in_code[i+4] = wd[8*i +: 6];
        end
        `OFF_OUT: begin
          next_s.out_code[0] = wd[6:0];
          next_s.out_code[1] = wd[14:8];
        end
        `OFF_SW: begin
          next_s.fsw_axis = wd[`SW_AXIS_EXTRA];
          next_s.fsw_proto = wd[`SW_PROTOCOL];
          next_s.axis_sel = wd[`SW_AXIS_LSB +: `AXIS_W];
        end
        `OFF_IRQ_CLR: clr = s.w_strb[0] ? s.w_data[`IRQ_W-1:0] : '0;
        `OFF_IRQ_EN: next_s.irq_en = wd[`IRQ_W-1:0];
        default: clr = '0;
      endcase
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = reg_hit(s.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s.bvalid && axi_bready_i) begin
      next_s.bvalid = 1'b0;
    end
    if (axi_awvalid_i && s.awready) begin
      next_s.aw_have = 1'b1;
      next_s.aw_addr = {axi_awaddr_i[7:2], 2'b00};
    end
    if (axi_wvalid_i && s.wready) begin
      next_s.w_have = 1'b1;
      next_s.w_data = axi_wdata_i;
      next_s.w_strb = axi_wstrb_i;
    end
    if (s.rvalid && axi_rready_i) begin
      next_s.rvalid = 1'b0;
    end else if (axi_arvalid_i && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_word(s, {axi_araddr_i[7:2], 2'b00}, clean);
      next_s.rresp = reg_hit({axi_araddr_i[7:2], 2'b00}) ?
                     `RESP_OKAY : `RESP_SLVERR;
    end
    next_s.awready = !next_s.aw_have && !next_s.bvalid;
    next_s.wready = !next_s.w_have && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;

    // sticky events, set wins over the clear
    ev[`IRQ_FAULT] = fault_set && !s.fault;
    ev[`IRQ_THERMAL] = thermal_open && !s.therm_open;
    ev[`IRQ_STOP] = (s.run != RUN_IDLE) && (next_s.run == RUN_IDLE);
    next_s.irq_stat = (s.irq_stat & ~clr) | ev;
    next_s.irq = |(next_s.irq_stat & next_s.irq_en);

    // output sources, echoes of every input function first
    for (int k = 1; k <= `FN_LAST; k++) begin
      src[k] = fn_active(next_s.in_code, clean, 6'(k));
    end
    src[`SRC_FAULT1] = !next_s.fault;
    src[`SRC_FAULT2] = !next_s.fault;
    src[`SRC_WARN] = warning_flag_i;
    src[`SRC_MOVING] = next_s.run != RUN_IDLE;
    src[`SRC_TLC] = torque_limited_flag_i;
    src[`SRC_VA] = speed_reached_flag_i;
    src[`SRC_BUSY] = busy_flag_i;
    src[`SRC_MPS] = main_power_flag_i;
    src[`SRC_DIR] = next_s.run == RUN_FWD;
    src[`SRC_PULSE] = pulse;
    for (int j = 0; j < `NUM_OUT; j++) begin
      next_s.out_term[j] = src[next_s.out_code[j]];
    end

    next_s.run_fwd = next_s.run == RUN_FWD;
    next_s.run_rev = next_s.run == RUN_REV;
    next_s.decel = next_s.run == RUN_DECEL;
    next_s.brake_release = !(BRAKE_FITTED && next_s.fault) &&
      (fn_active(s.in_code, clean, `FN_BRAKE) || next_s.run != RUN_IDLE);
    next_s.fault_led = next_s.fault && next_s.blink;
    next_s.torque_limit = fn_active(s.in_code, clean, `FN_TORQUE);
    next_s.panel_release = fn_active(s.in_code, clean, `FN_PANEL);
    for (int r = 0; r < 16; r++) begin
      next_s.remote[r] = fn_active(s.in_code, clean, `FN_REMOTE0 + 6'(r));
    end
    for (int m = 0; m < 4; m++) begin
      next_s.speed_sel[m] =
        fn_active(s.in_code, clean, `FN_SPEED_SEL0 + 6'(m));
    end
    next_s.axis_number = {next_s.fsw_axis, next_s.axis_sel};
    next_s.modbus_mode = next_s.fsw_proto;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s <= '0;
      s.in_code <= `IN_CODE_RST;
      s.out_code <= `OUT_CODE_RST;
      s.fsw_axis <= 1'(`SW_RST >> `SW_AXIS_EXTRA);
      s.fsw_proto <= 1'(`SW_RST >> `SW_PROTOCOL);
      // filtered levels start low, so no false thermal event after reset
      s.therm_open <= 1'b1;
      s.blink <= 1'b1;
      s.out_term <= '1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign axi_awready_o = s.awready;
  assign axi_wready_o = s.wready;
  assign axi_bvalid_o = s.bvalid;
  assign axi_bresp_o = s.bresp;
  assign axi_arready_o = s.arready;
  assign axi_rvalid_o = s.rvalid;
  assign axi_rdata_o = s.rdata;
  assign axi_rresp_o = s.rresp;
  assign run_fwd_o = s.run_fwd;
  assign run_rev_o = s.run_rev;
  assign decel_o = s.decel;
  assign brake_release_o = s.brake_release;
  assign fault_led_o = s.fault_led;
  assign out_term_o = s.out_term;
  assign torque_limit_enable_o = s.torque_limit;
  assign panel_release_o = s.panel_release;
  assign remote_bits_o = s.remote;
  assign speed_data_select_o = s.speed_sel;
  assign axis_number_o = s.axis_number;
  assign modbus_mode_o = s.modbus_mode;
  assign irq_o = s.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence trip_s;
    fault_set && !s.fault;
  endsequence
  sequence halted_s;
    !run_fwd_o && !run_rev_o && fault_led_o;
  endsequence

  fwd_start_a: assert property (
    (s.run == RUN_IDLE && forward_run && !reverse_run && !halt) |=> run_fwd_o && !run_rev_o)
    else $error("forward command did not start the motor");
  ramp_stop_a: assert property (
    (s.run == RUN_FWD && !forward_run && !halt && stop_ramp) |=>
    decel_o ##1 !run_fwd_o)
    else $error("ramped stop not entered");
  instant_stop_a: assert property (
    (s.run == RUN_REV && !reverse_run && !halt && !stop_ramp) |=>
    !decel_o && !run_rev_o)
    else $error("instant stop not taken");
  thermal_halt_a: assert property (
    thermal_open |=> !run_fwd_o && !run_rev_o && !decel_o)
    else $error("motor kept running with thermal contact open");
  fault_clear_a: assert property (
    (s.fault && fault_clr && !fault_set) |=> !s.fault && !fault_led_o)
    else $error("fault clear did not clear the fault");
  trip_stop_a: assert property (trip_s |=> halted_s)
    else $error("protective trip did not stop and blink");
  brake_hold_a: assert property (
    (fault_set && BRAKE_FITTED) |=> !brake_release_o)
    else $error("brake released during a trip");
  fault_out_a: assert property (
    (s.out_code[1] == `SRC_FAULT1) |-> out_term_o[1] == !s.fault)
    else $error("fault output level does not follow the fault");
  reset_map_a: assert property (
    $past(reset_i) |-> s.in_code == `IN_CODE_RST && s.out_code == `OUT_CODE_RST)
    else $error("terminal assignment not at reset default");
  axis_num_a: assert property (
    $stable({s.fsw_axis, s.axis_sel}) |->
    axis_number_o == {s.fsw_axis, s.axis_sel})
    else $error("axis number does not carry the extra bit");
  protocol_a: assert property (
    $rose(s.fsw_proto) |-> modbus_mode_o)
    else $error("protocol select not reflected");
endmodule // motor_io_top
`default_nettype wire

// *** test/io_ctrl_model.sv ***
// external controller that drives the seven discrete input terminals
// assumes the bench asks for commands as active-high requests
`timescale 1ns/1ps
`default_nettype none
module io_ctrl_model (
  input wire logic clk_i,
  input wire logic [6:0] cmd_i,
  output logic [6:0] in_term_o
);
  // -------------------------------------------------------------
  // terminal drive
  // -------------------------------------------------------------
  initial in_term_o = 7'h40;
  always @(posedge clk_i) begin
    // terminals 0 to 5 follow the request levels as asked
    in_term_o[5:0] <= cmd_i[5:0];
    // thermal contact is closed when healthy, a request opens it
    in_term_o[6] <= ~cmd_i[6];
  end
endmodule // io_ctrl_model
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench of the terminal logic with a register master
// assumes the design files and the controller model are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import motor_io_pkg::*;
  localparam int W = 12;
  logic clk_i = 0, reset_i = 1, shaft_tick_i = 0, protect_trip_i = 0;
  logic motor_still_i = 0, warning_flag_i = 0, torque_limited_flag_i = 0;
  logic speed_reached_flag_i = 0, busy_flag_i = 0, main_power_flag_i = 0;
  logic axi_awvalid_i = 0, axi_wvalid_i = 0, axi_bready_i = 0;
  logic axi_arvalid_i = 0, axi_rready_i = 0;
  logic [7:0] axi_awaddr_i = 0, axi_araddr_i = 0;
  logic [31:0] axi_wdata_i = 0;
  logic [3:0] axi_wstrb_i = 4'hF;
  logic axi_awready_o, axi_wready_o, axi_bvalid_o, axi_arready_o;
  logic axi_rvalid_o, run_fwd_o, run_rev_o, decel_o, brake_release_o;
  logic fault_led_o, torque_limit_enable_o, panel_release_o;
  logic modbus_mode_o, irq_o;
  logic [1:0] axi_bresp_o, axi_rresp_o, out_term_o, rsp;
  logic [31:0] axi_rdata_o, rd;
  logic [15:0] remote_bits_o;
  logic [3:0] speed_data_select_o;
  logic [4:0] axis_number_o, flg;
  logic [6:0] in_term_i, cmd = 0;
  logic [7:0] c, s;
  int errors = 0, num_checks = 0, k, n;
  logic [6:0] src [5] = '{7'h42, 7'h47, 7'h4D, 7'h50, 7'h52};

  always #4 clk_i = ~clk_i;
  io_ctrl_model ctrl (.clk_i(clk_i), .cmd_i(cmd), .in_term_o(in_term_i));
  motor_io_top #(.DEBOUNCE_CYCLES(3), .PULSE_CYCLES(5), .BLINK_CYCLES(4))
    DUT (.*);

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task end_sim;
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tmo(input int i);
    if (i >= 100) begin
      errors++;
      end_sim;
    end
  endtask
  task cyc(input int i);
    repeat (i) @(posedge clk_i);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bit ad, wd;
    ad = 0;
    wd = 0;
    axi_awaddr_i <= a;
    axi_wdata_i <= d;
    axi_awvalid_i <= 1;
    axi_wvalid_i <= 1;
    axi_bready_i <= 1;
    for (n = 0; n < 100 && !(ad && wd); n++) begin
      @(posedge clk_i);
      if (axi_awvalid_i && axi_awready_o) begin
        ad = 1;
        axi_awvalid_i <= 0;
      end
      if (axi_wvalid_i && axi_wready_o) begin
        wd = 1;
        axi_wvalid_i <= 0;
      end
    end
    tmo(n);
    for (n = 0; n < 100; n++) begin
      @(posedge clk_i);
      if (axi_bvalid_o) break;
    end
    tmo(n);
    rsp = axi_bresp_o;
  endtask
  task rdr(input logic [7:0] a);
    axi_araddr_i <= a;
    axi_arvalid_i <= 1;
    axi_rready_i <= 1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_i);
      if (axi_arready_o) break;
    end
    tmo(n);
    axi_arvalid_i <= 0;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_i);
      if (axi_rvalid_o) break;
    end
    tmo(n);
    rd = axi_rdata_o;
    rsp = axi_rresp_o;
  endtask
  // decoded outputs expected when only terminal 0 is high with code c
  function automatic logic [21:0] dec(input logic [7:0] c);
    logic [21:0] e;
    e = 0;
    if (c == 54) e[21] = 1;
    if (c == 27) e[20] = 1;
    if (c >= 32 && c <= 47) e[c-28] = 1;
    if (c >= 48 && c <= 51) e[c-48] = 1;
    return e;
  endfunction

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    s = $urandom(32'hC227BF71);
    cyc(12);
    reset_i <= 0;
    cyc(3);
    chk(out_term_o, 2'b10);
    rdr(8'h00);
    chk(rd, 32'h30130201);
    rdr(8'h04);
    chk(rd, 32'h00161418);
    rdr(8'h08);
    chk(rd, 32'h00004155);
    s = $urandom;
    wr(8'h0C, {24'h0, s[7:4], 2'b00, s[1:0]});
    cyc(3);
    chk(axis_number_o, {s[0], s[7:4]});
    chk(modbus_mode_o, s[1]);
    cmd <= 7'h05;
    cyc(W);
    chk({run_fwd_o, run_rev_o}, 2'b10);
    cmd <= 7'h04;
    cyc(W);
    chk({decel_o, run_fwd_o}, 2'b10);
    motor_still_i <= 1;
    cyc(4);
    chk(decel_o, 0);
    cmd <= 7'h02;
    cyc(W);
    chk({run_rev_o, decel_o}, 2'b10);
    cmd <= 7'h42;
    cyc(W);
    chk(run_rev_o, 0);
    cmd <= 7'h20;
    cyc(W);
    chk(brake_release_o, 1);
    cmd <= 0;
    shaft_tick_i <= 1;
    @(posedge clk_i);
    shaft_tick_i <= 0;
    k = 0;
    repeat (20) begin
      @(posedge clk_i);
      k += out_term_o[0];
    end
    chk(k, 5);
    wr(8'h1C, 32'h7);
    wr(8'h18, 32'h7);
    cmd <= 7'h01;
    cyc(W);
    protect_trip_i <= 1;
    @(posedge clk_i);
    protect_trip_i <= 0;
    k = 0;
    repeat (12) begin
      @(posedge clk_i);
      k += fault_led_o;
    end
    chk(k > 0 && k < 12, 1);
    chk({out_term_o[1], run_fwd_o, brake_release_o}, 0);
    chk(irq_o, 1);
    rdr(8'h14);
    chk(rd, 32'h5);
    cmd <= 7'h10;
    cyc(W);
    cmd <= 0;
    cyc(W);
    chk(out_term_o[1], 1);
    wr(8'h18, 32'h7);
    cyc(3);
    chk(irq_o, 0);
    rdr(8'h40);
    chk(rsp, 2'b10);
    chk(rd, 32'h0);
    cmd <= 7'h01;
    foreach (src[i]) begin
      c = (i == 0) ? 8'd54 : (i == 1) ? 8'd27 : (i == 2) ?
        8'd32 + {4'h0, s[3:0]} : 8'd48 + {6'h0, s[5:4]};
      if (i == 4) c = 8'd0;
      wr(8'h00, {24'h301302, c});
      cyc(W);
      chk({torque_limit_enable_o, panel_release_o, remote_bits_o,
           speed_data_select_o}, dec(c));
      flg = $urandom;
      {warning_flag_i, torque_limited_flag_i, speed_reached_flag_i,
       busy_flag_i, main_power_flag_i} <= flg;
      wr(8'h08, {16'h0, 8'h41, 1'b0, src[i]});
      cyc(4);
      chk(out_term_o[0], flg[4-i]);
    end
    end_sim;
  end
endmodule // testbench
`default_nettype wire
